// ### common/tlc_pkg.sv
/*
 * Constants for the thermal loop configuration register slice: register offsets,
 * reset values, field positions, conversion select codes and reading formats.
 * Assumes temperature readings arrive as unsigned 10-bit values in 0.25 degree steps.
 */
package tlc_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_LOCAL_REMOTE1_HYST = 8'h6D;
	localparam logic [7:0] OFS_REMOTE2_HYST = 8'h6E;
	localparam logic [7:0] OFS_LOGIC_TREE_TEST = 8'h6F;
	localparam logic [7:0] OFS_REMOTE1_TEMP_OFS = 8'h70;
	localparam logic [7:0] OFS_LOCAL_TEMP_OFS = 8'h71;
	localparam logic [7:0] OFS_REMOTE2_TEMP_OFS = 8'h72;
	localparam logic [7:0] OFS_MEAS_CTRL_TWO = 8'h73;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_LOCAL_REMOTE1_HYST = 8'h44;
	localparam logic [7:0] RST_REMOTE2_HYST = 8'h40;
	localparam logic [7:0] RST_LOGIC_TREE_TEST = 8'h00;
	localparam logic [7:0] RST_TEMP_OFS = 8'h00;
	localparam logic [7:0] RST_MEAS_CTRL_TWO = 8'h00;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int LOCAL_HYST_LSB = 0;
	localparam int REMOTE_ONE_HYST_LSB = 4;
	localparam int REMOTE_TWO_HYST_LSB = 4;
	localparam int HYST_W = 4;
	localparam int LOGIC_TREE_TEST_ON_BIT = 0;
	localparam int FAN_PRESENCE_DETECT_ON_BIT = 0;
	localparam int FOUR_WIRE_SEEN_LSB = 1;
	localparam int AVERAGING_OFF_BIT = 4;
	localparam int ATTENUATOR_BYPASS_BIT = 5;
	localparam int SINGLE_CHANNEL_CONVERT_BIT = 6;
	localparam int POWER_DOWN_REQUEST_BIT = 7;

	// ----------------------------------------------------------------
	// single-channel conversion select codes
	// ----------------------------------------------------------------
	localparam logic [2:0] SEL_CORE_VOLTAGE = 3'h1;
	localparam logic [2:0] SEL_SUPPLY_VOLTAGE = 3'h2;
	localparam logic [2:0] SEL_REMOTE_ONE = 3'h5;
	localparam logic [2:0] SEL_LOCAL = 3'h6;
	localparam logic [2:0] SEL_REMOTE_TWO = 3'h7;

	// ----------------------------------------------------------------
	// reading format: quarter degrees; offset step is half a degree
	// ----------------------------------------------------------------
	localparam int READ_W = 10;
	localparam int DEG_SHIFT = 2;
	localparam int OFFSET_SHIFT = 1;
	localparam logic [9:0] READ_MAX = 10'h3FF;

endpackage : tlc_pkg

// ### hdl/tlc_channel_loop.sv
/*
 * One temperature channel: applies the signed offset with saturation, then runs the
 * fan-start hysteresis and critical-limit hysteresis state for that channel.
 * Assumes threshold and limit inputs are whole degrees and held stable by their owner.
 */
module tlc_channel_loop (
	input wire logic clk_i, // core clock
	input wire logic srst_i, // synchronous reset, active high
	input wire logic [9:0] reading_i, // raw reading, quarter degrees
	input wire logic [7:0] offset_i, // two's complement, half degrees
	input wire logic [3:0] hyst_i, // hysteresis, whole degrees
	input wire logic [7:0] start_thr_i, // fan start threshold, whole degrees
	input wire logic [7:0] crit_lim_i, // critical limit, whole degrees
	output logic [9:0] corr_o, // corrected reading
	output logic run_o, // fan allowed to run
	output logic min_hold_o, // held at minimum duty in hysteresis band
	output logic crit_o // critical full drive for this channel
);

	logic signed [11:0] sum;
	logic [9:0] nxt_corr;
	logic [9:0] thr_q;
	logic [9:0] lim_q;
	logic [9:0] hyst_q;
	logic [9:0] thr_low;
	logic [9:0] lim_low;
	logic [9:0] corr_ff;
	logic run_ff;
	logic crit_ff;

	// ----------------------------------------------------------------
	// offset correction
	// ----------------------------------------------------------------
	// clamp instead of wrap: a wrapped reading would read hot as cold
	always_comb begin
		sum = $signed({2'b00, reading_i}) + $signed({{3{offset_i[7]}}, offset_i, 1'b0}); // [RULE8] [RULE9] [RULE10]
		if (sum < 0) begin
			nxt_corr = 10'h000; // [RULE19]
		end else if (sum > $signed({2'b00, tlc_pkg::READ_MAX})) begin
			nxt_corr = tlc_pkg::READ_MAX; // [RULE19]
		end else begin
			nxt_corr = sum[9:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			corr_ff <= 10'h000;
		end else begin
			corr_ff <= nxt_corr;
		end
	end

	// ----------------------------------------------------------------
	// hysteresis thresholds
	// ----------------------------------------------------------------
	always_comb begin
		thr_q = {start_thr_i, 2'b00};
		lim_q = {crit_lim_i, 2'b00};
		hyst_q = {4'h0, hyst_i, 2'b00};
		thr_low = (thr_q > hyst_q) ? thr_q - hyst_q : 10'h000;
		lim_low = (lim_q > hyst_q) ? lim_q - hyst_q : 10'h000;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			run_ff <= 1'b0;
		end else if (corr_ff > thr_q) begin
			run_ff <= 1'b1;
		end else if (corr_ff <= thr_low) begin
			run_ff <= 1'b0; // [RULE3]
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			crit_ff <= 1'b0;
		end else if (corr_ff > lim_q) begin
			crit_ff <= 1'b1; // [RULE4]
		end else if (corr_ff < lim_low) begin
			crit_ff <= 1'b0; // [RULE4]
		end
	end

	assign corr_o = corr_ff;
	assign run_o = run_ff;
	assign min_hold_o = run_ff && (corr_ff <= thr_q); // [RULE3]
	assign crit_o = crit_ff;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_corr_no_wrap: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE19]
		(reading_i == tlc_pkg::READ_MAX && !offset_i[7]) |=> corr_ff == tlc_pkg::READ_MAX)
		else $error("corrected reading wrapped at the top");
	chk_run_band_hold: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE3]
		(run_ff && corr_ff > thr_low && $stable(thr_q) && $stable(hyst_q)) |=> run_ff)
		else $error("fan stopped inside hysteresis band");
	chk_crit_release: assert property (@(posedge clk_i) disable iff (srst_i) // [RULE4]
		(crit_ff && corr_ff >= lim_low && corr_ff <= lim_q) |=> crit_ff)
		else $error("critical drive released early");

endmodule : tlc_channel_loop

// ### hdl/tlc_thermal_loop_config_regs.sv
/*
 * Thermal loop configuration registers: hysteresis, logic tree test enable, temperature
 * offsets and measurement control, plus the three channel hysteresis loops they steer.
 * Assumes a simple byte register port from the serial bus front end and a lock level
 * from the global configuration register; read data follows the address by one cycle.
 */
// Summary of operation
// RULE1 - hysteresis register holds local nibble low, remote one nibble high, 0-15 degrees
// RULE2 - second hysteresis register holds remote two hysteresis in its high nibble
// RULE3 - below start threshold fan stays at minimum duty until threshold minus hysteresis
// RULE4 - above critical limit drive full until below limit minus hysteresis
// RULE5 - software should keep every hysteresis at four degrees or more
// RULE6 - test bit zero set enters logic tree test; clearing it leaves
// RULE7 - software leaves the seven upper test register bits unwritten
// RULE8 - remote one offset, signed half degrees, added to remote one reading
// RULE9 - local offset, signed half degrees, added to local reading
// RULE10 - remote two offset, signed half degrees, added to remote two reading
// RULE11 - when lock is set all these registers ignore writes
// RULE12 - presence detect bit on makes bits three to one show four-wire fans
// RULE13 - fan detect bits are read-only, one when a four-wire fan is found
// RULE14 - averaging off bit stops measurement averaging
// RULE15 - attenuator bypass bit removes core voltage input attenuators
// RULE16 - single channel bit converts one selected input continuously
// RULE17 - select codes 1,2,5,6,7 pick inputs; 0,3,4 are reserved
// RULE18 - shutdown bit forces every pulse output to its fan-off level
// RULE19 - offsets applied before comparison, corrected reading saturates, never wraps
module tlc_thermal_loop_config_regs (
	input wire logic CORE_CLK_I, // core clock, 20 MHz
	input wire logic SRST_I, // synchronous reset, active high
	input wire logic [7:0] REG_ADDR_I, // register offset
	input wire logic REG_WR_EN_I, // write strobe, one cycle
	input wire logic [7:0] REG_WR_DATA_I, // write data
	output logic [7:0] REG_RD_DATA_O, // read data, one cycle after address
	input wire logic CFG_LOCK_I, // global configuration lock level
	input wire logic [9:0] TEMP_REMOTE_ONE_I, // raw remote one reading
	input wire logic [9:0] TEMP_LOCAL_I, // raw local reading
	input wire logic [9:0] TEMP_REMOTE_TWO_I, // raw remote two reading
	input wire logic [7:0] START_THR_REMOTE_ONE_I, // remote one fan start threshold
	input wire logic [7:0] START_THR_LOCAL_I, // local fan start threshold
	input wire logic [7:0] START_THR_REMOTE_TWO_I, // remote two fan start threshold
	input wire logic [7:0] CRIT_LIM_REMOTE_ONE_I, // remote one critical limit
	input wire logic [7:0] CRIT_LIM_LOCAL_I, // local critical limit
	input wire logic [7:0] CRIT_LIM_REMOTE_TWO_I, // remote two critical limit
	input wire logic [2:0] SINGLE_CHANNEL_CONVERT_SELECT_I, // single channel select field
	input wire logic [2:0] FOUR_WIRE_SENSE_I, // raw four-wire fan sense per output
	input wire logic OUTPUT_POLARITY_FLIP_I, // pulse output polarity inverted
	output logic [9:0] TEMP_REMOTE_ONE_CORR_O, // corrected remote one reading
	output logic [9:0] TEMP_LOCAL_CORR_O, // corrected local reading
	output logic [9:0] TEMP_REMOTE_TWO_CORR_O, // corrected remote two reading
	output logic [2:0] FAN_RUN_O, // per channel fan may run
	output logic [2:0] MIN_DUTY_HOLD_O, // per channel held at minimum duty
	output logic [2:0] CRIT_CH_O, // per channel critical state
	output logic CRIT_FULL_DRIVE_O, // drive outputs at full duty
	output logic LOGIC_TREE_TEST_ON_O, // logic tree test mode
	output logic AVERAGING_OFF_O, // averaging disabled
	output logic ATTENUATOR_BYPASS_O, // core voltage attenuators removed
	output logic SINGLE_CHANNEL_CONVERT_O, // single channel conversion
	output logic [2:0] SINGLE_CHANNEL_CONVERT_CHANNEL_O, // selected conversion input
	output logic SINGLE_CHANNEL_CONVERT_CHANNEL_VALID_O, // select code is not reserved
	output logic POWER_DOWN_REQUEST_O, // shutdown mode
	output logic PWM_FORCE_OFF_O, // force pulse outputs to fan-off level
	output logic PWM_OFF_LEVEL_O // fan-off level of pulse outputs
);

	logic [7:0] hyst_lr1_ff;
	logic [7:0] hyst_r2_ff;
	logic test_on_ff;
	logic [7:0] ofs_ff [3];
	logic presence_on_ff;
	logic [3:0] ctrl_hi_ff;
	logic [2:0] seen_ff;
	logic [2:0] single_channel_convert_ch_ff;
	logic single_channel_convert_valid_ff;
	logic [7:0] rd_data_ff;
	logic [7:0] nxt_rd_data;
	logic [7:0] ctrl_view;
	logic wr_ok;
	logic [9:0] reading [3];
	logic [7:0] start_thr [3];
	logic [7:0] crit_lim [3];
	logic [3:0] hyst [3];
	logic [9:0] corr [3];

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	// lock is a level from outside; once high every write here is dropped
	assign wr_ok = REG_WR_EN_I && !CFG_LOCK_I; // [RULE11]

	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			hyst_lr1_ff <= tlc_pkg::RST_LOCAL_REMOTE1_HYST;
		end else if (wr_ok && REG_ADDR_I == tlc_pkg::OFS_LOCAL_REMOTE1_HYST) begin
			hyst_lr1_ff <= REG_WR_DATA_I; // [RULE1]
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			hyst_r2_ff <= tlc_pkg::RST_REMOTE2_HYST;
		end else if (wr_ok && REG_ADDR_I == tlc_pkg::OFS_REMOTE2_HYST) begin
			hyst_r2_ff <= REG_WR_DATA_I; // [RULE2]
		end
	end

	// upper test bits are not stored, so a stray write cannot reach anything
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			test_on_ff <= tlc_pkg::RST_LOGIC_TREE_TEST[tlc_pkg::LOGIC_TREE_TEST_ON_BIT];
		end else if (wr_ok && REG_ADDR_I == tlc_pkg::OFS_LOGIC_TREE_TEST) begin
			test_on_ff <= REG_WR_DATA_I[tlc_pkg::LOGIC_TREE_TEST_ON_BIT]; // [RULE6] [RULE7]
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			ofs_ff[0] <= tlc_pkg::RST_TEMP_OFS;
			ofs_ff[1] <= tlc_pkg::RST_TEMP_OFS;
			ofs_ff[2] <= tlc_pkg::RST_TEMP_OFS;
		end else if (wr_ok) begin
			if (REG_ADDR_I == tlc_pkg::OFS_REMOTE1_TEMP_OFS) begin
				ofs_ff[0] <= REG_WR_DATA_I; // [RULE8]
			end
			if (REG_ADDR_I == tlc_pkg::OFS_LOCAL_TEMP_OFS) begin
				ofs_ff[1] <= REG_WR_DATA_I; // [RULE9]
			end
			if (REG_ADDR_I == tlc_pkg::OFS_REMOTE2_TEMP_OFS) begin
				ofs_ff[2] <= REG_WR_DATA_I; // [RULE10]
			end
		end
	end

	// detect bits 3:1 are not writable, so only bit 0 and bits 7:4 are stored
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			presence_on_ff <= tlc_pkg::RST_MEAS_CTRL_TWO[tlc_pkg::FAN_PRESENCE_DETECT_ON_BIT];
			ctrl_hi_ff <= tlc_pkg::RST_MEAS_CTRL_TWO[7:4];
		end else if (wr_ok && REG_ADDR_I == tlc_pkg::OFS_MEAS_CTRL_TWO) begin
			presence_on_ff <= REG_WR_DATA_I[tlc_pkg::FAN_PRESENCE_DETECT_ON_BIT]; // [RULE12]
			ctrl_hi_ff <= REG_WR_DATA_I[7:4]; // [RULE13]
		end
	end

	// ----------------------------------------------------------------
	// fan detect and conversion select
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			seen_ff <= 3'h0;
		end else begin
			seen_ff <= presence_on_ff ? FOUR_WIRE_SENSE_I : 3'h0; // [RULE12] [RULE13]
		end
	end

	// reserved codes keep the previous input rather than inventing one
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			single_channel_convert_ch_ff <= tlc_pkg::SEL_CORE_VOLTAGE;
			single_channel_convert_valid_ff <= 1'b0;
		end else begin
			unique case (SINGLE_CHANNEL_CONVERT_SELECT_I)
				tlc_pkg::SEL_CORE_VOLTAGE, tlc_pkg::SEL_SUPPLY_VOLTAGE,
				tlc_pkg::SEL_REMOTE_ONE, tlc_pkg::SEL_LOCAL, tlc_pkg::SEL_REMOTE_TWO: begin
					single_channel_convert_ch_ff <= SINGLE_CHANNEL_CONVERT_SELECT_I; // [RULE17]
					single_channel_convert_valid_ff <= 1'b1;
				end
				default: begin
					single_channel_convert_valid_ff <= 1'b0; // [RULE17]
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	assign ctrl_view = {ctrl_hi_ff, seen_ff, presence_on_ff};

	always_comb begin
		nxt_rd_data = tlc_pkg::RD_UNMAPPED;
		unique case (REG_ADDR_I)
			tlc_pkg::OFS_LOCAL_REMOTE1_HYST: nxt_rd_data = hyst_lr1_ff;
			tlc_pkg::OFS_REMOTE2_HYST: nxt_rd_data = hyst_r2_ff;
			tlc_pkg::OFS_LOGIC_TREE_TEST: nxt_rd_data = {7'h00, test_on_ff};
			tlc_pkg::OFS_REMOTE1_TEMP_OFS: nxt_rd_data = ofs_ff[0];
			tlc_pkg::OFS_LOCAL_TEMP_OFS: nxt_rd_data = ofs_ff[1];
			tlc_pkg::OFS_REMOTE2_TEMP_OFS: nxt_rd_data = ofs_ff[2];
			tlc_pkg::OFS_MEAS_CTRL_TWO: nxt_rd_data = ctrl_view;
			default: nxt_rd_data = tlc_pkg::RD_UNMAPPED;
		endcase
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			rd_data_ff <= 8'h00;
		end else begin
			rd_data_ff <= nxt_rd_data;
		end
	end

	assign REG_RD_DATA_O = rd_data_ff;

	// ----------------------------------------------------------------
	// channel loops: index 0 remote one, 1 local, 2 remote two
	// ----------------------------------------------------------------
	assign reading[0] = TEMP_REMOTE_ONE_I;
	assign reading[1] = TEMP_LOCAL_I;
	assign reading[2] = TEMP_REMOTE_TWO_I;
	assign start_thr[0] = START_THR_REMOTE_ONE_I;
	assign start_thr[1] = START_THR_LOCAL_I;
	assign start_thr[2] = START_THR_REMOTE_TWO_I;
	assign crit_lim[0] = CRIT_LIM_REMOTE_ONE_I;
	assign crit_lim[1] = CRIT_LIM_LOCAL_I;
	assign crit_lim[2] = CRIT_LIM_REMOTE_TWO_I;
	assign hyst[0] = hyst_lr1_ff[tlc_pkg::REMOTE_ONE_HYST_LSB +: tlc_pkg::HYST_W]; // [RULE1]
	assign hyst[1] = hyst_lr1_ff[tlc_pkg::LOCAL_HYST_LSB +: tlc_pkg::HYST_W]; // [RULE1]
	assign hyst[2] = hyst_r2_ff[tlc_pkg::REMOTE_TWO_HYST_LSB +: tlc_pkg::HYST_W]; // [RULE2]

	for (genvar ch = 0; ch < 3; ch++) begin : g_loop
		tlc_channel_loop u_loop (
			.clk_i(CORE_CLK_I),
			.srst_i(SRST_I),
			.reading_i(reading[ch]),
			.offset_i(ofs_ff[ch]),
			.hyst_i(hyst[ch]),
			.start_thr_i(start_thr[ch]),
			.crit_lim_i(crit_lim[ch]),
			.corr_o(corr[ch]),
			.run_o(FAN_RUN_O[ch]),
			.min_hold_o(MIN_DUTY_HOLD_O[ch]),
			.crit_o(CRIT_CH_O[ch])
		);
	end

	assign TEMP_REMOTE_ONE_CORR_O = corr[0];
	assign TEMP_LOCAL_CORR_O = corr[1];
	assign TEMP_REMOTE_TWO_CORR_O = corr[2];

	// ----------------------------------------------------------------
	// mode outputs
	// ----------------------------------------------------------------
	// shutdown outranks the critical full drive: the fans are meant to be off
	assign CRIT_FULL_DRIVE_O = (|CRIT_CH_O) && !POWER_DOWN_REQUEST_O; // [RULE4]
	assign LOGIC_TREE_TEST_ON_O = test_on_ff; // [RULE6]
	assign AVERAGING_OFF_O = ctrl_hi_ff[tlc_pkg::AVERAGING_OFF_BIT - 4]; // [RULE14]
	assign ATTENUATOR_BYPASS_O = ctrl_hi_ff[tlc_pkg::ATTENUATOR_BYPASS_BIT - 4]; // [RULE15]
	assign SINGLE_CHANNEL_CONVERT_O = ctrl_hi_ff[tlc_pkg::SINGLE_CHANNEL_CONVERT_BIT - 4]; // [RULE16]
	assign SINGLE_CHANNEL_CONVERT_CHANNEL_O = single_channel_convert_ch_ff; // [RULE17]
	assign SINGLE_CHANNEL_CONVERT_CHANNEL_VALID_O = single_channel_convert_valid_ff;
	assign POWER_DOWN_REQUEST_O = ctrl_hi_ff[tlc_pkg::POWER_DOWN_REQUEST_BIT - 4]; // [RULE18]
	assign PWM_FORCE_OFF_O = POWER_DOWN_REQUEST_O; // [RULE18]
	assign PWM_OFF_LEVEL_O = OUTPUT_POLARITY_FLIP_I; // [RULE18]

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_lock_blocks_write: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I) // [RULE11]
		CFG_LOCK_I |=> ($stable(hyst_lr1_ff) && $stable(hyst_r2_ff) && $stable(test_on_ff)
			&& $stable(ofs_ff[0]) && $stable(ofs_ff[1]) && $stable(ofs_ff[2])
			&& $stable(ctrl_hi_ff) && $stable(presence_on_ff)))
		else $error("locked register changed");
	chk_hyst_write_read: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I) // [RULE1]
		(REG_WR_EN_I && !CFG_LOCK_I && REG_ADDR_I == tlc_pkg::OFS_LOCAL_REMOTE1_HYST)
		|=> hyst_lr1_ff == $past(REG_WR_DATA_I))
		else $error("hysteresis write not stored");
	chk_test_mode_bit: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I) // [RULE6]
		(REG_WR_EN_I && !CFG_LOCK_I && REG_ADDR_I == tlc_pkg::OFS_LOGIC_TREE_TEST)
		|=> LOGIC_TREE_TEST_ON_O == $past(REG_WR_DATA_I[0]))
		else $error("test mode did not follow bit 0");
	chk_detect_hidden: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I) // [RULE12]
		(!presence_on_ff ##1 !presence_on_ff) |-> seen_ff == 3'h0)
		else $error("fan detect shown while detection off");
	chk_detect_mirror: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I) // [RULE13]
		presence_on_ff |=> seen_ff == $past(FOUR_WIRE_SENSE_I))
		else $error("fan detect bits do not follow sense");
	chk_read_ctrl: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I) // [RULE13]
		REG_ADDR_I == tlc_pkg::OFS_MEAS_CTRL_TWO |=> REG_RD_DATA_O == $past(ctrl_view))
		else $error("control register read mismatch");
	chk_shutdown_off: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I) // [RULE18]
		POWER_DOWN_REQUEST_O |-> (PWM_FORCE_OFF_O && !CRIT_FULL_DRIVE_O
			&& PWM_OFF_LEVEL_O == OUTPUT_POLARITY_FLIP_I))
		else $error("shutdown did not force fans off");
	chk_reserved_sel: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I) // [RULE17]
		(SINGLE_CHANNEL_CONVERT_SELECT_I == 3'h0 || SINGLE_CHANNEL_CONVERT_SELECT_I == 3'h3 || SINGLE_CHANNEL_CONVERT_SELECT_I == 3'h4)
		|=> (!SINGLE_CHANNEL_CONVERT_CHANNEL_VALID_O && $stable(SINGLE_CHANNEL_CONVERT_CHANNEL_O)))
		else $error("reserved select code accepted");
	chk_ctrl_modes: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I) // [RULE16]
		(REG_WR_EN_I && !CFG_LOCK_I && REG_ADDR_I == tlc_pkg::OFS_MEAS_CTRL_TWO)
		|=> (SINGLE_CHANNEL_CONVERT_O == $past(REG_WR_DATA_I[6])
			&& AVERAGING_OFF_O == $past(REG_WR_DATA_I[4])
			&& ATTENUATOR_BYPASS_O == $past(REG_WR_DATA_I[5])))
		else $error("control mode bits not applied");

endmodule : tlc_thermal_loop_config_regs

// ### verification/tlc_thermal_loop_config_regs_tb.sv
/*
 * Self-checking bench for the thermal loop configuration register slice.
 * Assumes the byte register port with read data one cycle after the address edge,
 * and drives every input at the falling edge of the 20 MHz core clock.
 */
module tlc_thermal_loop_config_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clk, rst, wr, lock, pol;
	logic [7:0] addr, wdata, rdata;
	logic [9:0] t_r1, t_lo, t_r2, c_r1, c_lo, c_r2;
	logic [2:0] sel, sense, run, hold, crit, chan, last;
	logic full, tst, averaging_off, att, single, chv, pdn, foff, flvl, v;
	logic [7:0] thr_lo, lim_lo;
	logic [5:0] modes;
	int n_errors = 0;
	int tests_run = 0;
	logic [7:0] rst_vals [7] = '{8'h44, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	tlc_thermal_loop_config_regs u_dut (.CORE_CLK_I(clk), .SRST_I(rst), .REG_ADDR_I(addr),
		.REG_WR_EN_I(wr), .REG_WR_DATA_I(wdata), .REG_RD_DATA_O(rdata), .CFG_LOCK_I(lock),
		.TEMP_REMOTE_ONE_I(t_r1), .TEMP_LOCAL_I(t_lo), .TEMP_REMOTE_TWO_I(t_r2),
		.START_THR_REMOTE_ONE_I(8'h28), .START_THR_LOCAL_I(thr_lo), .START_THR_REMOTE_TWO_I(8'h28),
		.CRIT_LIM_REMOTE_ONE_I(8'h32), .CRIT_LIM_LOCAL_I(lim_lo), .CRIT_LIM_REMOTE_TWO_I(8'h32),
		.SINGLE_CHANNEL_CONVERT_SELECT_I(sel), .FOUR_WIRE_SENSE_I(sense), .OUTPUT_POLARITY_FLIP_I(pol),
		.TEMP_REMOTE_ONE_CORR_O(c_r1), .TEMP_LOCAL_CORR_O(c_lo), .TEMP_REMOTE_TWO_CORR_O(c_r2),
		.FAN_RUN_O(run), .MIN_DUTY_HOLD_O(hold), .CRIT_CH_O(crit), .CRIT_FULL_DRIVE_O(full),
		.LOGIC_TREE_TEST_ON_O(tst), .AVERAGING_OFF_O(averaging_off), .ATTENUATOR_BYPASS_O(att),
		.SINGLE_CHANNEL_CONVERT_O(single), .SINGLE_CHANNEL_CONVERT_CHANNEL_O(chan), .SINGLE_CHANNEL_CONVERT_CHANNEL_VALID_O(chv),
		.POWER_DOWN_REQUEST_O(pdn), .PWM_FORCE_OFF_O(foff), .PWM_OFF_LEVEL_O(flvl));
	assign modes = {averaging_off, att, single, pdn, foff, flvl};

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic chk1(input string what, input logic exp, input logic got);
		chk(what, {9'h000, exp}, {9'h000, got});
	endtask : chk1
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
		// strobe low across one edge so back-to-back writes each show a fresh pulse
		@(negedge clk);
	endtask : wr_reg
	// two edges so the answer has landed whichever edge loads it
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		addr = a;
		tick(2);
		chk($sformatf("reg %h", a), {2'b00, exp}, {2'b00, rdata});
	endtask : rd_chk
	task automatic lo(input logic [9:0] t, input logic er, input logic eh, input logic ec);
		t_lo = t;
		tick(3);
		chk1("run", er, run[1]);
		chk1("hold", eh, hold[1]);
		chk1("crit", ec, crit[1]);
		chk1("full", ec, full);
	endtask : lo
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1; wr = 1'b0; lock = 1'b0; pol = 1'b0; addr = 8'h00; wdata = 8'h00;
		t_r1 = 10'h000; t_lo = 10'h000; t_r2 = 10'h000; sel = 3'h0; sense = 3'h0;
		thr_lo = 8'h28;
		lim_lo = 8'h32;
		tick(5);
		rst = 1'b0;
		for (int i = 0; i < 7; i++) rd_chk(8'h6D + 8'(i), rst_vals[i]);
		rd_chk(8'h74, 8'h00);
		$display("test reset done");
		wr_reg(8'h6D, 8'hA5);
		rd_chk(8'h6D, 8'hA5);
		wr_reg(8'h6E, 8'h90);
		rd_chk(8'h6E, 8'h90);
		// local hysteresis 5 degrees: limit 200, clear below 180; start 160, off at 140
		lo(10'd201, 1'b1, 1'b0, 1'b1);
		lo(10'd181, 1'b1, 1'b0, 1'b1);
		lo(10'd179, 1'b1, 1'b0, 1'b0);
		lo(10'd150, 1'b1, 1'b1, 1'b0);
		lo(10'd141, 1'b1, 1'b1, 1'b0);
		lo(10'd140, 1'b0, 1'b0, 1'b0);
		lo(10'd150, 1'b0, 1'b0, 1'b0);
		$display("test hysteresis done");
		wr_reg(8'h71, 8'h01);
		wr_reg(8'h70, 8'hFC);
		wr_reg(8'h72, 8'h7F);
		t_lo = 10'd100; t_r1 = 10'd4; t_r2 = 10'h3F0;
		tick(3);
		chk("local corr", 10'd102, c_lo);
		chk("remote one corr", 10'd0, c_r1);
		chk("remote two corr", 10'h3FF, c_r2);
		chk1("remote two crit", 1'b1, crit[2]);
		chk1("full drive", 1'b1, full);
		rd_chk(8'h70, 8'hFC);
		$display("test offsets done");
		pol = 1'b1; sense = 3'b101;
		wr_reg(8'h73, 8'hFF);
		rd_chk(8'h73, 8'hFB);
		chk("ctrl", 10'h03F, {4'h0, modes});
		chk1("full in shutdown", 1'b0, full);
		sense = 3'b000; pol = 1'b0;
		wr_reg(8'h73, 8'h00);
		rd_chk(8'h73, 8'h00);
		chk("ctrl off", 10'h000, {4'h0, modes});
		chk1("full after shutdown", 1'b1, full);
		$display("test control done");
		wr_reg(8'h6F, 8'h01);
		chk1("test on", 1'b1, tst);
		rd_chk(8'h6F, 8'h01);
		wr_reg(8'h6F, 8'h00);
		chk1("test off", 1'b0, tst);
		$display("test logic tree done");
		last = 3'h1;
		for (int i = 0; i < 8; i++) begin
			sel = 3'(i);
			tick(2);
			v = (i == 1) || (i == 2) || (i >= 5);
			if (v) last = 3'(i);
			chk1("select valid", v, chv);
			chk("select chan", {7'h00, last}, {7'h00, chan});
		end
		$display("test select done");
		lock = 1'b1;
		wr_reg(8'h6D, 8'h44);
		wr_reg(8'h73, 8'h10);
		rd_chk(8'h6D, 8'hA5);
		rd_chk(8'h73, 8'h00);
		lock = 1'b0;
		$display("test lock done");
		end_sim();
	end
endmodule : tlc_thermal_loop_config_regs_tb
